// >>> bench/mcpt_checker_asserts.sv
// Bus-port assertions for the capture/PWM timer
`timescale 1ns/1ps
`include "mcpt_defs.vh"
module mcpt_checker (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pulse output watched for coverage
	input wire logic        channel_b_pin_out
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// High when a word address hits a register
	function automatic logic mapped(input logic [11:0] a);
		logic [9:0] i;
		i = a[11:2];
		return (i >= `MCPT_IDX_MODE && i <= `MCPT_IDX_COUNT) || i == `MCPT_IDX_GRA
			|| i == `MCPT_IDX_GRB || i == `MCPT_IDX_GRC || i == `MCPT_IDX_GRD
			|| (i >= `MCPT_IDX_CTL2 && i <= `MCPT_IDX_OUT_MASK);
	endfunction

	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_one_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_has_cause: assert property ($rose(pready) |-> $past(psel && !penable))
		else $error("ready without setup");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_unmapped_refused: assert property (pready && paddr[1:0] == 2'h0 && !mapped(paddr)
		|-> pslverr)
		else $error("unmapped access accepted");
	a_mapped_accepted: assert property (pready && paddr[1:0] == 2'h0 && mapped(paddr)
		|-> !pslverr)
		else $error("mapped access refused");
	a_mode_fixed_one: assert property (pready && !pwrite && paddr[11:2] == `MCPT_IDX_MODE
		|-> prdata[6])
		else $error("mode spare bit not one");
	a_status_fixed_ones: assert property (pready && !pwrite
		&& paddr[11:2] == `MCPT_IDX_STATUS |-> prdata[6:4] == 3'h7)
		else $error("status spare bits not one");
	a_upper_read_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	a_rdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved without read");

	// Main scenarios reached
	c_refused: cover property (pready && pslverr);
	c_pulse: cover property ($rose(channel_b_pin_out));
	c_count_read: cover property (pready && !pwrite && paddr[11:2] == `MCPT_IDX_COUNT);
endmodule

bind mcpt_timer mcpt_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .channel_b_pin_out(channel_b_pin_out));

// >>> bench/mcpt_pins.sv
// Model of the pins and clocks around the timer
`timescale 1ns/1ps
module mcpt_pins (
	// Controls from the bench
	input  wire logic       ext_run,
	input  wire logic       trg,
	input  wire logic [3:0] drive,
	// Device side of the channel pins
	input  wire logic [3:0] dev_out,
	input  wire logic [3:0] dev_oe_n,
	// Levels seen by the device
	output logic            osc,
	output logic            ext_clk,
	output logic            trg_pin,
	output logic [3:0]      pin_in
);
	// Free-running 40 MHz oscillator, phase kept off the bus clock edges
	initial begin
		osc = 1'b0;
		#0.25;
		forever #12.5 osc = ~osc;
	end
	// External count clock runs only when asked, else rests low; edges avoid the bus clock
	initial begin
		ext_clk = 1'b0;
		#2;
		forever #20 ext_clk = ext_run ? ~ext_clk : 1'b0;
	end
	// Trigger line kept apart from channel A
	assign trg_pin = trg;
	// Device level wins while it drives, else the far side
	assign pin_in = (~dev_oe_n & dev_out) | (dev_oe_n & drive);
endmodule

// >>> bench/mcpt_timer_tb.sv
// Self-checking bench for the capture/PWM timer
`timescale 1ns/1ps
`include "mcpt_defs.vh"
module mcpt_timer_tb;
	// Bus master signals
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	wire  [31:0] prdata;
	wire         pready, pslverr;
	// Far-side controls and pins
	logic        ext_run = 1'b0;
	logic        trg     = 1'b0;
	logic [3:0]  drive   = 4'h0;
	wire  [3:0]  pin_in, pin_out, pin_oe_n;
	wire         osc, ext_clk, trg_pin;
	// Bookkeeping
	logic [31:0] rd;
	logic        err;
	logic [15:0] diff;
	int          n_errors    = 0;
	int          checks_done = 0;
	int          rises       = 0;
	int          togs        = 0;
	// Rows: register, value written, value read back
	logic [9:0]  r_idx [10] = '{`MCPT_IDX_GRA, `MCPT_IDX_GRB, `MCPT_IDX_GRC, `MCPT_IDX_COUNT,
		`MCPT_IDX_CTL2, `MCPT_IDX_FILTER, `MCPT_IDX_OUT_MASK, `MCPT_IDX_IRQ_EN,
		`MCPT_IDX_IO0, `MCPT_IDX_IO1};
	logic [31:0] r_wr [10] = '{32'hFFFFA5A5, 32'h1234, 32'hFFFF, 32'hBEEF, 32'h3, 32'h1F,
		32'hF, 32'hF, 32'h77, 32'h66};
	logic [31:0] r_rd [10] = '{32'hA5A5, 32'h1234, 32'hFFFF, 32'hBEEF, 32'h3, 32'h1F,
		32'hF, 32'hF, 32'h77, 32'h66};
	// Counts per source code over the timed window
	logic [15:0] rate [8] = '{16'h143, 16'hA1, 16'h51, 16'h28, 16'hA, 16'h40, 16'h67, 16'h0};

	// Clock and pulse counters
	always #4 pclk = ~pclk;
	always @(posedge pin_out[1]) rises++;
	always @(pin_out[0]) togs++;

	mcpt_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .channel_a_pin_in(pin_in[0]), .channel_a_pin_out(pin_out[0]),
		.channel_a_pin_oe_n(pin_oe_n[0]), .channel_b_pin_in(pin_in[1]),
		.channel_b_pin_out(pin_out[1]), .channel_b_pin_oe_n(pin_oe_n[1]),
		.channel_c_pin_in(pin_in[2]), .channel_c_pin_out(pin_out[2]),
		.channel_c_pin_oe_n(pin_oe_n[2]), .channel_d_pin_in(pin_in[3]),
		.channel_d_pin_out(pin_out[3]), .channel_d_pin_oe_n(pin_oe_n[3]),
		.external_count_clock_pin(ext_clk), .internal_40mhz_clock(osc),
		.triggered_pwm_mode_trigger_pin(trg_pin));

	mcpt_pins far (.ext_run(ext_run), .trg(trg), .drive(drive), .dev_out(pin_out),
		.dev_oe_n(pin_oe_n), .osc(osc), .ext_clk(ext_clk), .trg_pin(trg_pin), .pin_in(pin_in));

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Window compare
	task automatic rng(input logic [31:0] seen, input int lo, input int hi, input string what);
		chk({31'h0, seen >= lo && seen <= hi}, 32'h1, what);
	endtask
	// One bus transfer, held until ready is seen
	task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d);
	endtask
	task automatic rdc(input logic [9:0] idx, input logic [31:0] exp, input string what);
		apb(1'b0, idx, 32'h0);
		chk(rd, exp, what);
	endtask
	// Verdict
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		final_report();
	end

	// Main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`MCPT_IDX_MODE, 32'h48, "mode reset");
		rdc(`MCPT_IDX_STATUS, 32'h70, "status reset");
		for (int i = 0; i < 10; i++) begin
			wr(r_idx[i], r_wr[i]);
			rdc(r_idx[i], r_rd[i], "row read-back");
		end
		apb(1'b0, 10'h127, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		// Compare match toggles A and clears the counter
		wr(`MCPT_IDX_OUT_MASK, 32'h0);
		wr(`MCPT_IDX_IO0, 32'h3);
		wr(`MCPT_IDX_IO1, 32'h0);
		wr(`MCPT_IDX_GRA, 32'h3);
		wr(`MCPT_IDX_COUNT, 32'h0);
		wr(`MCPT_IDX_STATUS, 32'h0);
		wr(`MCPT_IDX_CTL1, 32'h80);
		wr(`MCPT_IDX_MODE, 32'hC8);
		togs = 0;
		repeat (40) @(posedge pclk);
		rng(togs, 9, 11, "toggles");
		chk({28'h0, pin_oe_n}, 32'h0, "compare enables");
		wr(`MCPT_IDX_MODE, 32'h48);
		apb(1'b0, `MCPT_IDX_COUNT, 32'h0);
		rng(rd, 0, 3, "cleared count");
		apb(1'b0, `MCPT_IDX_STATUS, 32'h0);
		chk({31'h0, rd[0]}, 32'h1, "match flag");
		// Capture on A, C stays idle
		wr(`MCPT_IDX_CTL1, 32'h0);
		wr(`MCPT_IDX_IO0, 32'h4);
		wr(`MCPT_IDX_IO1, 32'h4);
		wr(`MCPT_IDX_FILTER, 32'h0);
		wr(`MCPT_IDX_GRA, 32'h0);
		wr(`MCPT_IDX_GRC, 32'h0);
		wr(`MCPT_IDX_COUNT, 32'h0);
		wr(`MCPT_IDX_MODE, 32'hC8);
		repeat (50) @(posedge pclk);
		drive <= 4'h1;
		repeat (10) @(posedge pclk);
		chk({28'h0, pin_oe_n}, 32'h5, "capture enables");
		wr(`MCPT_IDX_MODE, 32'h48);
		apb(1'b0, `MCPT_IDX_GRA, 32'h0);
		rng(rd, 45, 70, "captured count");
		rdc(`MCPT_IDX_GRC, 32'h0, "idle channel");
		// Triggered one-shot; C capture setting must be ignored
		wr(`MCPT_IDX_CTL2, 32'h2);
		wr(`MCPT_IDX_GRA, 32'h14);
		wr(`MCPT_IDX_GRB, 32'h5);
		wr(`MCPT_IDX_COUNT, 32'h0);
		wr(`MCPT_IDX_MODE, 32'hC0);
		rises = 0;
		drive <= 4'h4;
		repeat (30) @(posedge pclk);
		chk(rises, 32'h0, "pulses before trigger");
		chk({28'h0, pin_oe_n}, 32'hD, "triggered enables");
		rdc(`MCPT_IDX_GRC, 32'h0, "capture in triggered mode");
		rdc(`MCPT_IDX_COUNT, 32'h0, "waiting count");
		trg <= 1'b1;
		repeat (4) @(posedge pclk);
		trg <= 1'b0;
		repeat (60) @(posedge pclk);
		chk(rises, 32'h1, "one-shot pulses");
		chk({31'h0, pin_out[1]}, 32'h0, "one-shot end level");
		// Continuous pulses on B, period from A
		wr(`MCPT_IDX_MODE, 32'h48);
		wr(`MCPT_IDX_CTL1, 32'h80);
		wr(`MCPT_IDX_IO0, 32'h0);
		wr(`MCPT_IDX_GRA, 32'h9);
		wr(`MCPT_IDX_GRB, 32'h4);
		wr(`MCPT_IDX_COUNT, 32'h0);
		wr(`MCPT_IDX_MODE, 32'hC9);
		rises = 0;
		repeat (100) @(posedge pclk);
		rng(rises, 9, 11, "pulse periods");
		// Every source code from near the top of the count
		wr(`MCPT_IDX_STATUS, 32'h0);
		for (int c = 0; c < 8; c++) begin
			wr(`MCPT_IDX_MODE, 32'h48);
			wr(`MCPT_IDX_COUNT, 32'hFFF0);
			wr(`MCPT_IDX_CTL1, {25'h0, c[2:0], 4'h0});
			wr(`MCPT_IDX_MODE, 32'hC8);
			ext_run <= 1'b1;
			repeat (320) @(posedge pclk);
			ext_run <= 1'b0;
			wr(`MCPT_IDX_MODE, 32'h48);
			apb(1'b0, `MCPT_IDX_COUNT, 32'h0);
			diff = rd[15:0] - 16'hFFF0 - rate[c] + 16'h0003;
			rng({16'h0, diff}, 0, 6, "source rate");
		end
		apb(1'b0, `MCPT_IDX_STATUS, 32'h0);
		chk({31'h0, rd[7]}, 32'h1, "wrap flag");
		// Reset with the timer stopped restores defaults
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`MCPT_IDX_MODE, 32'h48, "mode after reset");
		rdc(`MCPT_IDX_GRA, 32'h0, "general after reset");
		final_report();
	end
endmodule

// >>> hdl/mcpt_defs.vh
// Register indices, field positions, reset values and encodings of the capture/PWM timer
`ifndef MCPT_DEFS_VH
`define MCPT_DEFS_VH

// Register indices (byte address on the bus is four times the index)
`define MCPT_IDX_MODE        10'h120
`define MCPT_IDX_CTL1        10'h121
`define MCPT_IDX_IRQ_EN      10'h122
`define MCPT_IDX_STATUS      10'h123
`define MCPT_IDX_IO0         10'h124
`define MCPT_IDX_IO1         10'h125
`define MCPT_IDX_COUNT       10'h126
`define MCPT_IDX_GRA         10'h128
`define MCPT_IDX_GRB         10'h12A
`define MCPT_IDX_GRC         10'h12C
`define MCPT_IDX_GRD         10'h12E
`define MCPT_IDX_CTL2        10'h130
`define MCPT_IDX_FILTER      10'h131
`define MCPT_IDX_OUT_MASK    10'h132

// Reset values
`define MCPT_RST_MODE        8'h48
`define MCPT_RST_BYTE        8'h00
`define MCPT_RST_WORD        16'h0000
`define MCPT_RST_COUNT       16'h0000
`define MCPT_STATUS_ONES     8'h70
`define MCPT_MODE_ONES       8'h40

// Mode register fields
`define MCPT_MODE_TRIGGERED_PWM_MODE_SEL   3
`define MCPT_MODE_START      7

// Control one fields
`define MCPT_CTL1_SRC_LSB    4
`define MCPT_CTL1_COUNTER_CLEAR_SELECT       7

// Control two fields
`define MCPT_CTL2_REPEAT     0
`define MCPT_CTL2_TRG_WAIT   1

// Status fields
`define MCPT_STAT_OVF        7

// Channel I/O control field: bit 2 capture select, bits 1:0 compare action
`define MCPT_IO_CAPTURE      2
`define MCPT_ACT_LOW         2'h1
`define MCPT_ACT_HIGH        2'h2
`define MCPT_ACT_TOGGLE      2'h3

// Input filter: bit for the trigger input
`define MCPT_FILT_TRG        4

// Count source codes
`define MCPT_SRC_DIV1        3'h0
`define MCPT_SRC_DIV2        3'h1
`define MCPT_SRC_DIV4        3'h2
`define MCPT_SRC_DIV8        3'h3
`define MCPT_SRC_DIV32       3'h4
`define MCPT_SRC_EXT         3'h5
`define MCPT_SRC_OSC         3'h6

// Prescaler terminal masks
`define MCPT_PRE_MAX2        5'h01
`define MCPT_PRE_MAX4        5'h03
`define MCPT_PRE_MAX8        5'h07
`define MCPT_PRE_MAX32       5'h1F

// Widths
`define MCPT_CNT_W           16
`define MCPT_ADDR_W          12
`define MCPT_ALL_ONES        16'hFFFF

`endif

// >>> hdl/mcpt_timer.v
// Multi-mode capture, compare and PWM timer with an APB register slave
`timescale 1ns/1ps
`include "mcpt_defs.vh"

// Summary of operation
// - One 16-bit counter shared by four channels
// - Codes 000b-100b count on system clock basis
// - Code 110b counts on 40 MHz oscillator edges
// - Sources: clock/1,2,4,8,32, external rising edge or 40 MHz oscillator edge
// - Capture copies counter to general register on trigger
// - Compare match changes the channel output
// - PWM mode outputs continuous pulses on channels B, C and D
// - TRIGGERED_PWM_MODE waits trigger, delay, then one-shot or repeat
// - Channel function selected per channel independently
// - TRIGGERED_PWM_MODE waveform from counter and registers, fixed roles
// - Dedicated trigger input starts the TRIGGERED_PWM_MODE sequence
// - Channel I/O control only effective in timer mode
// - Control two only effective in TRIGGERED_PWM_MODE mode
// - Filter only for capture and TRIGGERED_PWM_MODE trigger
// - Output mask only for compare, PWM, TRIGGERED_PWM_MODE
// - Four 16-bit general registers used in all modes
// - Mode, control, enable, status, counter always active
// - Clear select: clear on A match, else free-run
// - TRIGGERED_PWM_MODE select 0 chooses TRIGGERED_PWM_MODE; PWM bits need 1
module mcpt_timer (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Channel pins, split into input, output and active-low output enable
	input  wire        channel_a_pin_in,
	output reg         channel_a_pin_out,
	output reg         channel_a_pin_oe_n,
	input  wire        channel_b_pin_in,
	output reg         channel_b_pin_out,
	output reg         channel_b_pin_oe_n,
	input  wire        channel_c_pin_in,
	output reg         channel_c_pin_out,
	output reg         channel_c_pin_oe_n,
	input  wire        channel_d_pin_in,
	output reg         channel_d_pin_out,
	output reg         channel_d_pin_oe_n,
	// Count clock and trigger inputs
	input  wire        external_count_clock_pin,
	input  wire        internal_40mhz_clock,
	input  wire        triggered_pwm_mode_trigger_pin
);

	// Software registers
	reg  [7:0]  timer_mode_select;      // Mode and start control
	reg  [7:0]  timer_control_one;      // Levels, source, clear select
	reg  [7:0]  timer_interrupt_enable; // Stored only, no interrupt logic here
	reg  [7:0]  status_flags;           // Sticky event flags
	reg  [7:0]  channel_io_control_0;   // Channels A and B
	reg  [7:0]  channel_io_control_1;   // Channels C and D
	reg  [15:0] timer_count_value;      // The shared counter
	reg  [15:0] gr [0:3];               // General registers A to D
	reg  [7:0]  timer_control_two;      // TRIGGERED_PWM_MODE options
	reg  [7:0]  input_filter_select;    // Filter enables
	reg  [7:0]  output_mask_enable;     // Output disables

	// Internal state
	reg  [4:0]  pre;                    // Prescaler
	reg         ext_q;                  // Last external clock sample
	reg         osc_q;                  // Last oscillator sample
	reg         start_q;                // Last start bit
	reg         triggered_pwm_mode_run;               // TRIGGERED_PWM_MODE sequence active
	reg  [4:0]  in_q;                   // Registered pin inputs
	reg  [4:0]  filt;                   // Filtered pin inputs
	reg  [4:0]  sel_q;                  // Last selected inputs, for edges
	reg  [9:0]  hist;                   // Two older samples per input
	reg  [3:0]  pin_out;                // Channel output states
	reg  [31:0] next_prdata;            // Read data mux
	reg         next_map;               // Address hits a register
	reg         src_tick;               // Count source event
	reg  [15:0] next_count;             // Counter next value

	// Decoded bus access
	// Registers sit one per 32-bit word, so the word index is the byte address over four;
	// the two low address bits are not decoded.
	wire [9:0]  idx     = paddr[11:2];
	wire        setup   = psel & ~penable & ~pready;
	wire        wr      = psel & penable & pready & pwrite & ~pslverr;
	wire        start   = timer_mode_select[`MCPT_MODE_START];
	wire        triggered_pwm_mode    = ~timer_mode_select[`MCPT_MODE_TRIGGERED_PWM_MODE_SEL];
	wire [2:0]  src     = timer_control_one[`MCPT_CTL1_SRC_LSB +: 3];
	wire [15:0] io_all  = {channel_io_control_1, channel_io_control_0};
	wire [4:0]  raw_in  = {triggered_pwm_mode_trigger_pin, channel_d_pin_in, channel_c_pin_in,
		channel_b_pin_in, channel_a_pin_in};

	// Per-channel decode
	wire [3:0]  ch_pwm;                 // Channel in PWM mode
	wire [3:0]  ch_cap;                 // Channel in input capture
	wire [3:0]  ch_cmp;                 // Channel in output compare
	wire [3:0]  ch_drv;                 // Channel drives its pin
	wire [3:0]  match;                  // Compare match on a count event
	wire [3:0]  cap_evt;                // Capture event
	wire [4:0]  sel_in;                 // Filtered or plain input
	wire [4:0]  rise;                   // Rising edge of selected input

	// Count source event selection
	always @* begin
		case (src)
			`MCPT_SRC_DIV1:  src_tick = 1'b1;
			`MCPT_SRC_DIV2:  src_tick = ((pre & `MCPT_PRE_MAX2) == `MCPT_PRE_MAX2);
			`MCPT_SRC_DIV4:  src_tick = ((pre & `MCPT_PRE_MAX4) == `MCPT_PRE_MAX4);
			`MCPT_SRC_DIV8:  src_tick = ((pre & `MCPT_PRE_MAX8) == `MCPT_PRE_MAX8);
			`MCPT_SRC_DIV32: src_tick = (pre == `MCPT_PRE_MAX32);
			`MCPT_SRC_EXT:   src_tick = external_count_clock_pin & ~ext_q;
			`MCPT_SRC_OSC:   src_tick = internal_40mhz_clock & ~osc_q;
			default:         src_tick = 1'b0;
		endcase
	end

	// Counting is gated by start and, in TRIGGERED_PWM_MODE, by the running sequence
	// A stopped counter keeps its value so software can read and preload it.
	wire        tick    = start & src_tick & (~triggered_pwm_mode | triggered_pwm_mode_run);
	wire        clr_a   = triggered_pwm_mode | (timer_control_one[`MCPT_CTL1_COUNTER_CLEAR_SELECT] & ~ch_cap[0]);
	wire        ovf     = tick & (timer_count_value == `MCPT_ALL_ONES) & ~(clr_a & match[0]);
	wire        one_end = triggered_pwm_mode & match[0] & ~timer_control_two[`MCPT_CTL2_REPEAT];
	wire        triggered_pwm_mode_go = triggered_pwm_mode & start & ~triggered_pwm_mode_run & ~one_end &
		(timer_control_two[`MCPT_CTL2_TRG_WAIT] ? rise[4] : ~start_q);

	// Per-channel logic and per-input filter
	genvar i;
	generate
		for (i = 0; i < 5; i = i + 1) begin : g_in
			// Input is accepted after three equal samples
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					filt[i] <= 1'b0;
				end else if ((in_q[i] == hist[2*i]) && (in_q[i] == hist[2*i+1])) begin
					filt[i] <= in_q[i];
				end
			end
			// Filter used only for capture channels and the trigger
			assign sel_in[i] = input_filter_select[i] ? filt[i] : in_q[i];
			assign rise[i]   = sel_in[i] & ~sel_q[i];
		end
		for (i = 0; i < 4; i = i + 1) begin : g_ch
			// Channel A has no PWM bit; it sets the PWM period
			if (i == 0) begin : g_a
				assign ch_pwm[i] = 1'b0;
			end else begin : g_bcd
				assign ch_pwm[i] = ~triggered_pwm_mode & timer_mode_select[i-1];
			end
			// I/O control counts only in timer mode
			assign ch_cap[i]  = ~triggered_pwm_mode & ~ch_pwm[i] & io_all[4*i+`MCPT_IO_CAPTURE];
			assign ch_cmp[i]  = ~triggered_pwm_mode & ~ch_pwm[i] & ~io_all[4*i+`MCPT_IO_CAPTURE];
			assign match[i]   = tick & (timer_count_value == gr[i]);
			assign cap_evt[i] = ch_cap[i] & rise[i];
			// Only channel B is an output in TRIGGERED_PWM_MODE; mask never affects capture
			assign ch_drv[i]  = (triggered_pwm_mode ? (i == 1) : (ch_cmp[i] | ch_pwm[i])) &
				~output_mask_enable[i];
			// Output state
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_out[i] <= 1'b0;
				end else if (!start) begin
					// Stopped: output sits at its programmed level
					pin_out[i] <= timer_control_one[i];
				end else if (triggered_pwm_mode) begin
					// Active after wait time (B match), inactive at end (A match)
					if ((i == 1) && match[0]) begin
						pin_out[i] <= timer_control_one[i];
					end else if ((i == 1) && match[1]) begin
						pin_out[i] <= ~timer_control_one[i];
					end
				end else if (ch_pwm[i]) begin
					// Period set by A, pulse edge by own register
					if (match[0]) begin
						pin_out[i] <= timer_control_one[i];
					end else if (match[i]) begin
						pin_out[i] <= ~timer_control_one[i];
					end
				end else if (ch_cmp[i] && match[i]) begin
					// Compare action on a match
					case (io_all[4*i +: 2])
						`MCPT_ACT_LOW:    pin_out[i] <= 1'b0;
						`MCPT_ACT_HIGH:   pin_out[i] <= 1'b1;
						`MCPT_ACT_TOGGLE: pin_out[i] <= ~pin_out[i];
						default:          pin_out[i] <= pin_out[i];
					endcase
				end
			end
		end
	endgenerate

	// Input sampling, edge memory and count source history
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_q    <= 5'h00;
			hist    <= 10'h000;
			sel_q   <= 5'h00;
			ext_q   <= 1'b0;
			osc_q   <= 1'b0;
			pre     <= 5'h00;
			start_q <= 1'b0;
		end else begin
			in_q    <= raw_in;
			hist    <= {in_q[4], hist[9], in_q[3], hist[7], in_q[2], hist[5],
				in_q[1], hist[3], in_q[0], hist[1]};
			sel_q   <= sel_in;
			ext_q   <= external_count_clock_pin;
			osc_q   <= internal_40mhz_clock;
			pre     <= pre + 5'h01;
			start_q <= start;
		end
	end

	// TRIGGERED_PWM_MODE sequence state
	// The trigger is edge detected, so a held trigger starts only one sequence.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			triggered_pwm_mode_run <= 1'b0;
		end else if (!triggered_pwm_mode || !start || one_end) begin
			// One-shot ends at the A match; leaving TRIGGERED_PWM_MODE or stopping aborts
			triggered_pwm_mode_run <= 1'b0;
		end else if (triggered_pwm_mode_go) begin
			triggered_pwm_mode_run <= 1'b1;
		end
	end

	// Counter next value
	always @* begin
		if (clr_a && match[0]) begin
			next_count = `MCPT_RST_COUNT;
		end else if (tick) begin
			next_count = timer_count_value + 16'h0001;
		end else begin
			next_count = timer_count_value;
		end
	end

	// Control registers and counter
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_mode_select      <= `MCPT_RST_MODE;
			timer_control_one      <= `MCPT_RST_BYTE;
			timer_interrupt_enable <= `MCPT_RST_BYTE;
			channel_io_control_0   <= `MCPT_RST_BYTE;
			channel_io_control_1   <= `MCPT_RST_BYTE;
			timer_control_two      <= `MCPT_RST_BYTE;
			input_filter_select    <= `MCPT_RST_BYTE;
			output_mask_enable     <= `MCPT_RST_BYTE;
			timer_count_value      <= `MCPT_RST_COUNT;
		end else begin
			// Software write to the counter beats counting
			if (wr && idx == `MCPT_IDX_COUNT) begin
				timer_count_value <= pwdata[15:0];
			end else begin
				timer_count_value <= next_count;
			end
			if (wr) begin
				case (idx)
					`MCPT_IDX_MODE:     timer_mode_select      <= pwdata[7:0] | `MCPT_MODE_ONES;
					`MCPT_IDX_CTL1:     timer_control_one      <= pwdata[7:0];
					`MCPT_IDX_IRQ_EN:   timer_interrupt_enable <= pwdata[7:0];
					`MCPT_IDX_IO0:      channel_io_control_0   <= pwdata[7:0];
					`MCPT_IDX_IO1:      channel_io_control_1   <= pwdata[7:0];
					`MCPT_IDX_CTL2:     timer_control_two      <= pwdata[7:0];
					`MCPT_IDX_FILTER:   input_filter_select    <= pwdata[7:0];
					`MCPT_IDX_OUT_MASK: output_mask_enable     <= pwdata[7:0];
					default:            timer_interrupt_enable <= timer_interrupt_enable;
				endcase
			end
		end
	end

	// General registers: capture wins over a software write
	integer k;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (k = 0; k < 4; k = k + 1) begin
				gr[k] <= `MCPT_RST_WORD;
			end
		end else begin
			for (k = 0; k < 4; k = k + 1) begin
				if (cap_evt[k]) begin
					gr[k] <= timer_count_value;
				end else if (wr && idx == (`MCPT_IDX_GRA + 10'h002 * k[9:0])) begin
					gr[k] <= pwdata[15:0];
				end
			end
		end
	end

	// Status flags: write 0 clears, a new event in the same cycle wins
	// A software clear that meets a new event must not lose it,
	// so the event bits are ORed in after the clear mask.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_flags <= `MCPT_STATUS_ONES;
		end else begin
			status_flags <= ((wr && idx == `MCPT_IDX_STATUS) ?
				(status_flags & pwdata[7:0]) : status_flags) |
				{ovf, 3'h0, (ch_cap & cap_evt) | (~ch_cap & match)} |
				`MCPT_STATUS_ONES;
		end
	end

	// Read data mux and address map
	always @* begin
		next_map    = 1'b1;
		next_prdata = 32'h00000000;
		case (idx)
			`MCPT_IDX_MODE:     next_prdata[7:0]  = timer_mode_select;
			`MCPT_IDX_CTL1:     next_prdata[7:0]  = timer_control_one;
			`MCPT_IDX_IRQ_EN:   next_prdata[7:0]  = timer_interrupt_enable;
			`MCPT_IDX_STATUS:   next_prdata[7:0]  = status_flags;
			`MCPT_IDX_IO0:      next_prdata[7:0]  = channel_io_control_0;
			`MCPT_IDX_IO1:      next_prdata[7:0]  = channel_io_control_1;
			`MCPT_IDX_COUNT:    next_prdata[15:0] = timer_count_value;
			`MCPT_IDX_GRA:      next_prdata[15:0] = gr[0];
			`MCPT_IDX_GRB:      next_prdata[15:0] = gr[1];
			`MCPT_IDX_GRC:      next_prdata[15:0] = gr[2];
			`MCPT_IDX_GRD:      next_prdata[15:0] = gr[3];
			`MCPT_IDX_CTL2:     next_prdata[7:0]  = timer_control_two;
			`MCPT_IDX_FILTER:   next_prdata[7:0]  = input_filter_select;
			`MCPT_IDX_OUT_MASK: next_prdata[7:0]  = output_mask_enable;
			default:            next_map          = 1'b0;
		endcase
	end

	// APB answer: one access cycle, read data captured at setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~next_map;
			if (setup && !pwrite) begin
				prdata <= next_map ? next_prdata : 32'h00000000;
			end
		end
	end

	// Pin outputs and enables
	// Levels pass two flop stages (pin_out, then the pin) and enables one, so an enable can lead its level by a cycle.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_a_pin_out  <= 1'b0;
			channel_b_pin_out  <= 1'b0;
			channel_c_pin_out  <= 1'b0;
			channel_d_pin_out  <= 1'b0;
			channel_a_pin_oe_n <= 1'b1;
			channel_b_pin_oe_n <= 1'b1;
			channel_c_pin_oe_n <= 1'b1;
			channel_d_pin_oe_n <= 1'b1;
		end else begin
			channel_a_pin_out  <= pin_out[0];
			channel_b_pin_out  <= pin_out[1];
			channel_c_pin_out  <= pin_out[2];
			channel_d_pin_out  <= pin_out[3];
			channel_a_pin_oe_n <= ~ch_drv[0];
			channel_b_pin_oe_n <= ~ch_drv[1];
			channel_c_pin_oe_n <= ~ch_drv[2];
			channel_d_pin_oe_n <= ~ch_drv[3];
		end
	end

endmodule
